// ==== rtl/lamp_clock_emi_and_sampling_control.sv ====
// lamp current sampling rate, power-down and EMI spread/step control
`timescale 1ns/1ns
module lamp_clock_emi_and_sampling_control
  import lamp_emi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lampClkPin,
  input wire logic powerDownPin,
  input wire logic freqStepEnablePin,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  output logic [7:0] regRdData,
  output logic sampleStrobe,
  output logic powerDown,
  output logic controllerReset,
  output logic faultClear,
  output logic [5:0] spreadTenthsPct,
  output logic spreadShapeRandom,
  output logic stepUp,
  output logic stepDown,
  output logic [2:0] stepPercent,
  output logic modRateValid,
  output logic [2:0] modRateCode
);

  logic [1:0] rstSync_q;
  logic rstInt_n;
  logic [7:0] controlTwo_q;
  logic [7:0] spreadStep_q;
  logic [2:0] lampSync_q;
  logic [2:0] pdSync_q;
  logic [2:0] stepSync_q;
  logic lampLvl_q;
  logic pdLvl_q;
  logic stepLvl_q;
  logic lampPrev_q;
  logic lampEdge;
  logic pdEff;
  logic stepEnEff;
  logic [1:0] spreadCode;
  logic [2:0] stepCode;
  logic [5:0] sampleCnt_q;
  logic [5:0] samplePeriod;
  logic [7:0] regRdData_q;
  logic sampleStrobe_q;
  logic powerDown_q;
  logic controllerReset_q;
  logic faultClear_q;
  logic [5:0] spreadTenthsPct_q;
  logic spreadShapeRandom_q;
  logic stepUp_q;
  logic stepDown_q;
  logic [2:0] stepPercent_q;
  logic modRateValid_q;
  logic [2:0] modRateCode_q;

  function automatic logic [5:0] periodOf(input logic [1:0] code);
    periodOf = SAMPLE_PERIOD_BASE << code;
  endfunction

  function automatic logic [5:0] spreadOf(input logic [1:0] code);
    unique case (code)
      2'h0: spreadOf = SPREAD_TENTHS_NONE;
      2'h1: spreadOf = SPREAD_TENTHS_1P5;
      2'h2: spreadOf = SPREAD_TENTHS_3P0;
      default: spreadOf = SPREAD_TENTHS_6P0;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstInt_n = rstSync_q[1];

  // pins: three stages, the filtered level moves only when stages two and three agree
  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      lampSync_q <= 3'h0;
      pdSync_q <= 3'h0;
      stepSync_q <= 3'h0;
      lampLvl_q <= 1'b0;
      pdLvl_q <= 1'b0;
      stepLvl_q <= 1'b0;
      lampPrev_q <= 1'b0;
    end else begin
      lampSync_q <= {lampSync_q[1:0], lampClkPin};
      pdSync_q <= {pdSync_q[1:0], powerDownPin};
      stepSync_q <= {stepSync_q[1:0], freqStepEnablePin};
      if (lampSync_q[1] == lampSync_q[2]) begin
        lampLvl_q <= lampSync_q[2];
      end
      if (pdSync_q[1] == pdSync_q[2]) begin
        pdLvl_q <= pdSync_q[2];
      end
      if (stepSync_q[1] == stepSync_q[2]) begin
        stepLvl_q <= stepSync_q[2];
      end
      lampPrev_q <= lampLvl_q;
    end
  end

  assign lampEdge = lampLvl_q & ~lampPrev_q;
  assign pdEff = controlTwo_q[POWER_DOWN_BIT_POS] | pdLvl_q;
  assign stepEnEff = spreadStep_q[FREQ_STEP_ENABLE_POS] | stepLvl_q;
  assign spreadCode = spreadStep_q[SPREAD_AMOUNT_HI_POS:SPREAD_AMOUNT_LO_POS];
  assign stepCode = spreadStep_q[FREQ_STEP_SEL_2_POS:FREQ_STEP_SEL_0_POS];
  assign samplePeriod = periodOf(controlTwo_q[SAMPLE_RATE_SEL_HI_POS:SAMPLE_RATE_SEL_LO_POS]);

  // registers are never touched by power-down, so the host can always reach them
  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      controlTwo_q <= CONTROL_TWO_RESET;
      spreadStep_q <= SPREAD_STEP_CONTROL_RESET;
    end else if (regWrEn) begin
      if (regAddr == CONTROL_TWO_OFFSET) begin
        controlTwo_q <= regWrData & CONTROL_TWO_WMASK;
      end
      if (regAddr == SPREAD_STEP_CONTROL_OFFSET) begin
        spreadStep_q <= regWrData & SPREAD_STEP_CONTROL_WMASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      regRdData_q <= 8'h00;
    end else if (regAddr == CONTROL_TWO_OFFSET) begin
      regRdData_q <= controlTwo_q;
    end else if (regAddr == SPREAD_STEP_CONTROL_OFFSET) begin
      regRdData_q <= spreadStep_q;
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // sample counter restarts on a rate change only at its next wrap; a period shorter
  // than the count is caught by the >= compare
  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      sampleCnt_q <= 6'h00;
      sampleStrobe_q <= 1'b0;
    end else if (pdEff) begin
      sampleCnt_q <= 6'h00;
      sampleStrobe_q <= 1'b0;
    end else if (lampEdge) begin
      if (sampleCnt_q >= samplePeriod - 6'h01) begin
        sampleCnt_q <= 6'h00;
        sampleStrobe_q <= 1'b1;
      end else begin
        sampleCnt_q <= sampleCnt_q + 6'h01;
        sampleStrobe_q <= 1'b0;
      end
    end else begin
      sampleStrobe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      powerDown_q <= 1'b0;
      controllerReset_q <= 1'b0;
      faultClear_q <= 1'b0;
    end else begin
      powerDown_q <= pdEff;
      controllerReset_q <= pdEff;
      faultClear_q <= pdEff;
    end
  end

  // while powered down the spread, shape and rate-valid controls fall to nominal; modRateCode still follows the step field
  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      spreadTenthsPct_q <= SPREAD_TENTHS_NONE;
      spreadShapeRandom_q <= 1'b0;
      modRateValid_q <= 1'b0;
      modRateCode_q <= 3'h0;
    end else begin
      spreadTenthsPct_q <= pdEff ? SPREAD_TENTHS_NONE : spreadOf(spreadCode);
      spreadShapeRandom_q <= spreadStep_q[SPREAD_SHAPE_SELECT_POS] & ~pdEff;
      modRateValid_q <= (spreadCode != 2'h0) & ~pdEff;
      modRateCode_q <= (spreadCode != 2'h0) ? stepCode : 3'h0;
    end
  end

  // code 111 has no defined step, so it leaves the lamp at nominal
  always_ff @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      stepUp_q <= 1'b0;
      stepDown_q <= 1'b0;
      stepPercent_q <= 3'h0;
    end else if (stepEnEff && spreadCode == 2'h0 && !pdEff && stepCode != STEP_CODE_UNUSED) begin
      stepUp_q <= stepCode < STEP_DOWN_FIRST;
      stepDown_q <= stepCode >= STEP_DOWN_FIRST;
      stepPercent_q <= (stepCode < STEP_DOWN_FIRST) ? stepCode + 3'h1 : stepCode - 3'h3;
    end else begin
      stepUp_q <= 1'b0;
      stepDown_q <= 1'b0;
      stepPercent_q <= 3'h0;
    end
  end

  assign regRdData = regRdData_q;
  assign sampleStrobe = sampleStrobe_q;
  assign powerDown = powerDown_q;
  assign controllerReset = controllerReset_q;
  assign faultClear = faultClear_q;
  assign spreadTenthsPct = spreadTenthsPct_q;
  assign spreadShapeRandom = spreadShapeRandom_q;
  assign stepUp = stepUp_q;
  assign stepDown = stepDown_q;
  assign stepPercent = stepPercent_q;
  assign modRateValid = modRateValid_q;
  assign modRateCode = modRateCode_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstInt_n);

  a_pd_or_pin: assert property (pdLvl_q && !controlTwo_q[7] |=> powerDown_q)
    else $error("power-down pin alone did not power down");
  a_pd_clears_fault: assert property (powerDown_q |-> faultClear_q && controllerReset_q)
    else $error("power-down without reset and fault clear");
  a_pd_no_sample: assert property (pdEff |=> !sampleStrobe_q)
    else $error("sample taken while powered down");
  a_sample_period: assert property (sampleStrobe_q |-> $past(sampleCnt_q) >= $past(samplePeriod) - 6'h01)
    else $error("sample strobe before period elapsed");
  a_sample_spacing: assert property (sampleStrobe_q && samplePeriod == 6'h04 && $stable(samplePeriod)
    |=> !sampleStrobe_q [*8])
    else $error("samples closer than four lamp cycles");
  a_regs_in_pd: assert property (powerDown_q && regWrEn && regAddr == SPREAD_STEP_CONTROL_OFFSET
    |=> spreadStep_q == ($past(regWrData) & SPREAD_STEP_CONTROL_WMASK))
    else $error("register write lost during power-down");
  a_step_gated: assert property ((stepUp_q || stepDown_q) |-> $past(spreadCode) == 2'h0)
    else $error("step applied with spread on");
  a_step_nominal: assert property (!stepEnEff |=> !stepUp_q && !stepDown_q && stepPercent_q == 3'h0)
    else $error("step applied while disabled");
  a_spread_map: assert property (spreadCode == 2'h3 && !pdEff |=> spreadTenthsPct_q == 6'h3C)
    else $error("spread code 11 not six percent");
  a_modrate_sel: assert property (spreadCode != 2'h0 && !pdEff
    |=> modRateValid_q && modRateCode_q == $past(stepCode))
    else $error("modulation rate not taken from step field");

  c_sample: cover property (sampleStrobe_q);
  c_pd_pin: cover property (pdLvl_q && !controlTwo_q[7] ##1 powerDown_q);
  c_step_down: cover property (stepDown_q && stepPercent_q == 3'h3);
  c_mod_rate: cover property (modRateValid_q && modRateCode_q == 3'h6);

endmodule

// ==== include/lamp_emi_pkg.sv ====
// constants for the lamp sampling, power-down and EMI control block
package lamp_emi_pkg;
  // register byte offsets on the serial register port
  localparam logic [7:0] CONTROL_TWO_OFFSET = 8'hF5;
  localparam logic [7:0] SPREAD_STEP_CONTROL_OFFSET = 8'hF6;
  // values after reset
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h08;
  localparam logic [7:0] SPREAD_STEP_CONTROL_RESET = 8'h00;
  // writable bits; reserved bits read as zero
  localparam logic [7:0] CONTROL_TWO_WMASK = 8'h9F;
  localparam logic [7:0] SPREAD_STEP_CONTROL_WMASK = 8'hF7;
  // control_two fields
  localparam int SAMPLE_RATE_SEL_LO_POS = 3;
  localparam int SAMPLE_RATE_SEL_HI_POS = 4;
  localparam int POWER_DOWN_BIT_POS = 7;
  // spread_step_control fields
  localparam int SPREAD_AMOUNT_LO_POS = 0;
  localparam int SPREAD_AMOUNT_HI_POS = 1;
  localparam int SPREAD_SHAPE_SELECT_POS = 2;
  localparam int FREQ_STEP_ENABLE_POS = 4;
  localparam int FREQ_STEP_SEL_0_POS = 5;
  localparam int FREQ_STEP_SEL_2_POS = 7;
  // sample period in lamp clock cycles for code 00; each code step doubles it
  localparam logic [5:0] SAMPLE_PERIOD_BASE = 6'h04;
  // spread in tenths of a percent
  localparam logic [5:0] SPREAD_TENTHS_NONE = 6'h00;
  localparam logic [5:0] SPREAD_TENTHS_1P5 = 6'h0F;
  localparam logic [5:0] SPREAD_TENTHS_3P0 = 6'h1E;
  localparam logic [5:0] SPREAD_TENTHS_6P0 = 6'h3C;
  // first step-select code that steps down
  localparam logic [2:0] STEP_DOWN_FIRST = 3'h4;
  localparam logic [2:0] STEP_CODE_UNUSED = 3'h7;
endpackage

// ==== verification/lamp_osc_model.sv ====
// lamp oscillator stand-in that drives the lamp clock pin
`timescale 1ns/1ns
module lamp_osc_model #(parameter int HALF = 5) (
  input wire logic clk,
  input wire logic run,
  output logic lampClk
);
  int cnt = 0;
  // each level is held 5 clocks so the 3-clock pin filter always sees it
  always @(negedge clk) begin
    if (!run) begin
      lampClk <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lampClk <= ~lampClk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== verification/lamp_clock_emi_and_sampling_control_tb.sv ====
// self-checking bench for the lamp sampling, power-down and EMI control block
`timescale 1ns/1ns
module lamp_clock_emi_and_sampling_control_tb;
  import lamp_emi_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lampRun = 1'b0;
  logic lampClkPin;
  logic powerDownPin = 1'b0;
  logic freqStepEnablePin = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regRdData, rdv;
  logic sampleStrobe, powerDown, controllerReset, faultClear;
  logic [5:0] spreadTenthsPct;
  logic spreadShapeRandom, stepUp, stepDown, modRateValid;
  logic [2:0] stepPercent, modRateCode;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  logic [5:0] spreadTbl [4] = '{6'h00, 6'h0F, 6'h1E, 6'h3C};

  always #4 clk = ~clk;

  lamp_osc_model lamp_osc_model_i (.clk(clk), .run(lampRun), .lampClk(lampClkPin));

  lamp_clock_emi_and_sampling_control lamp_clock_emi_and_sampling_control_i (
    .clk(clk), .rst_n(rst_n), .lampClkPin(lampClkPin), .powerDownPin(powerDownPin),
    .freqStepEnablePin(freqStepEnablePin), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdData(regRdData), .sampleStrobe(sampleStrobe), .powerDown(powerDown),
    .controllerReset(controllerReset), .faultClear(faultClear), .spreadTenthsPct(spreadTenthsPct),
    .spreadShapeRandom(spreadShapeRandom), .stepUp(stepUp), .stepDown(stepDown),
    .stepPercent(stepPercent), .modRateValid(modRateValid), .modRateCode(modRateCode));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    repeat (2) @(negedge clk);
    d = regRdData;
  endtask

  // pin inputs pass a synchroniser and filter, so allow them time to land
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask

  task automatic wait_strobe(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (sampleStrobe !== 1'b1 && cnt < 400);
  endtask

  task automatic t_regs();
    rd(CONTROL_TWO_OFFSET, rdv);
    chk(rdv, 8'h08);
    rd(SPREAD_STEP_CONTROL_OFFSET, rdv);
    chk(rdv, 8'h00);
    rd(8'h10, rdv);
    chk(rdv, 8'h00);
    wr(CONTROL_TWO_OFFSET, 8'hFF);
    rd(CONTROL_TWO_OFFSET, rdv);
    chk(rdv, 8'h9F);
    wr(SPREAD_STEP_CONTROL_OFFSET, 8'hFF);
    rd(SPREAD_STEP_CONTROL_OFFSET, rdv);
    chk(rdv, 8'hF7);
    wr(SPREAD_STEP_CONTROL_OFFSET, 8'h00);
    wr(CONTROL_TWO_OFFSET, 8'h00);
  endtask

  task automatic t_rate();
    lampRun = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(CONTROL_TWO_OFFSET, 8'(c << 3));
      wait_strobe(n);
      wait_strobe(n);
      chk(8'(n >> 1), 8'(20 << c));
    end
  endtask

  task automatic t_pdown();
    wr(CONTROL_TWO_OFFSET, 8'h80);
    settle();
    chk({5'h00, powerDown, controllerReset, faultClear}, 8'h07);
    wr(SPREAD_STEP_CONTROL_OFFSET, 8'h01);
    rd(SPREAD_STEP_CONTROL_OFFSET, rdv);
    chk(rdv, 8'h01);
    chk({2'h0, spreadTenthsPct}, 8'h00);
    wait_strobe(n);
    chk(8'(n >> 1), 8'hC8);
    wr(CONTROL_TWO_OFFSET, 8'h00);
    powerDownPin = 1'b1;
    settle();
    chk({5'h00, powerDown, controllerReset, faultClear}, 8'h07);
    powerDownPin = 1'b0;
    settle();
    chk({5'h00, powerDown, controllerReset, faultClear}, 8'h00);
  endtask

  task automatic t_spread();
    for (int s = 0; s < 4; s++) begin
      wr(SPREAD_STEP_CONTROL_OFFSET, {3'(2 * s), 2'b00, 1'b1, 2'(s)});
      settle();
      chk({2'h0, spreadTenthsPct}, {2'h0, spreadTbl[s]});
      chk({7'h00, spreadShapeRandom}, 8'h01);
      chk({4'h0, modRateValid, modRateCode}, (s == 0) ? 8'h00 : {4'h0, 1'b1, 3'(2 * s)});
    end
  endtask

  task automatic t_step();
    logic [2:0] p;
    for (int k = 0; k < 8; k++) begin
      wr(SPREAD_STEP_CONTROL_OFFSET, {3'(k), 1'b1, 4'h0});
      settle();
      p = (k < 4) ? 3'(k + 1) : (k < 7) ? 3'(k - 3) : 3'h0;
      chk({3'h0, stepUp, stepDown, stepPercent}, {3'h0, k < 4, k >= 4 && k < 7, p});
    end
    wr(SPREAD_STEP_CONTROL_OFFSET, 8'h11);
    settle();
    chk({3'h0, stepUp, stepDown, stepPercent}, 8'h00);
    wr(SPREAD_STEP_CONTROL_OFFSET, 8'h20);
    settle();
    chk({3'h0, stepUp, stepDown, stepPercent}, 8'h00);
    chk({7'h00, spreadShapeRandom}, 8'h00);
    freqStepEnablePin = 1'b1;
    settle();
    chk({3'h0, stepUp, stepDown, stepPercent}, 8'h12);
  endtask

  // the longest test path is a few thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_rate();
    t_pdown();
    t_spread();
    t_step();
    stop_test();
  end
endmodule
